// ===== dv/wk_host_model.sv
/*
  Upstream host model: reports bus idle as a suspend detection, signals
  host resume on request and counts resume request cycles from the device.
  Assumes testbench strobes on clk, one cycle each.
*/
`timescale 1ns/10ps
module wk_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Testbench requests
  input  wire logic       idle_go,
  input  wire logic       wake_go,
  // Device side
  input  wire logic       resume_req,
  output logic            suspend_det,
  output logic            host_resume,
  output logic [7:0]      resume_cnt
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      suspend_det <= 1'b0;
      host_resume <= 1'b0;
    end else begin
      suspend_det <= idle_go;
      host_resume <= wake_go;
    end
  end

  // Each high cycle counts; a correct pulse adds exactly one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resume_cnt <= 8'h00;
    end else if (resume_req) begin
      resume_cnt <= resume_cnt + 8'h01;
    end
  end
endmodule

// ===== dv/wk_wake_irq_tb_top.sv
/*
  Self-checking bench of the wake event interrupt block: APB firmware
  master, random pin events, suspend and resume cases.
  Assumes the host model and the package are compiled first.
*/
`timescale 1ns/10ps
`include "wk_consts.svh"
module wk_wake_irq_tb_top
  import wk_pkg::*;
;
  localparam int unsigned WAIT_CYC = 20;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        idle_go, wake_go, susp_det, host_res, clk_stop, res_req, irq;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [4:0]  pins;
  logic [7:0]  res_cnt, cnt0;
  int          err_total, comparisons, cyc;

  wk_wake_irq #(.RESUME_WAIT_CYCLES(WAIT_CYC)) i_dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS_POWER(pins[0]), .PORT3_PIN2(pins[1]),
    .PORT3_PIN3(pins[2]), .PORT3_PIN4(pins[3]), .PORT3_PIN5(pins[4]),
    .SUSPEND_DET(susp_det), .HOST_RESUME(host_res), .CORE_CLK_STOP(clk_stop),
    .RESUME_REQ(res_req), .WAKE_IRQ(irq));

  wk_host_model i_host (
    .clk(clk), .rst(rst), .idle_go(idle_go), .wake_go(wake_go),
    .resume_req(res_req), .suspend_det(susp_det), .host_resume(host_res),
    .resume_cnt(res_cnt));

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Setup, access until ready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(n, x, q);
  endtask

  task automatic toggle(input int s);
    pins[s] <= ~pins[s];
    cw(6);
  endtask

  task automatic host_wake();
    wake_go <= 1'b1;
    @(posedge clk);
    wake_go <= 1'b0;
    cw(4);
  endtask

  // Firmware order: flag first, then sources
  task automatic clear_all();
    wr(`WK_OFS_STATUS, 32'h04);
    wr(`WK_OFS_WAKEUP, 32'h1f);
  endtask

  task automatic enter_susp(input logic [31:0] ctl);
    wr(`WK_OFS_CONTROL, ctl);
    idle_go <= 1'b1;
    @(posedge clk);
    idle_go <= 1'b0;
    cw(3);
    rd("suspend request", `WK_OFS_STATUS, 32'h10);
    wr(`WK_OFS_STATUS, 32'h10);
    check("clock stop", {31'h0, ctl[6]}, {31'h0, clk_stop});
    cnt0 = res_cnt;
  endtask

  function automatic int cfg_bit(input int s);
    return (s < 3) ? s + 3 : s - 1;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, idle_go, wake_go} = 6'h20;
    {paddr, pwdata, pins} = '0;
    void'($urandom(32'ha9b929d0));
    cw(10);
    rst <= 1'b0;
    cw(4);
    for (int i = 0; i < 6; i++)
      rd("reset value", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    $display("test registers done");

    wr(`WK_OFS_MASK, 32'h04);
    wr(`WK_OFS_CONFIG, 32'h3c);
    for (int s = 0; s < 5; s++) begin
      cw($urandom_range(5, 1));
      toggle(s);
      check("irq raised", 32'h1, {31'h0, irq});
      rd("one pending", `WK_OFS_STATUS, 32'h04);
      rd("sources", `WK_OFS_WAKEUP, (32'h1 << (s + 1)) - 1);
    end
    wr(`WK_OFS_STATUS, 32'h04);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd("sources kept", `WK_OFS_WAKEUP, 32'h1f);
    cnt0 = 8'($urandom_range(31, 0));
    wr(`WK_OFS_WAKEUP, {24'h0, cnt0});
    rd("source cleared", `WK_OFS_WAKEUP, {27'h0, ~cnt0[4:0]});
    clear_all();
    $display("test events done");

    wr(`WK_OFS_MASK, 32'h0);
    toggle(0);
    check("masked irq", 32'h0, {31'h0, irq});
    rd("masked source", `WK_OFS_WAKEUP, 32'h01);
    clear_all();
    wr(`WK_OFS_MASK, 32'h04);
    for (int s = 1; s < 5; s++) begin
      wr(`WK_OFS_CONFIG, 32'h3c & ~(32'h1 << cfg_bit(s)));
      toggle(s);
      check("disabled irq", 32'h0, {31'h0, irq});
      rd("disabled source", `WK_OFS_WAKEUP, 32'h0);
    end
    wr(`WK_OFS_CONFIG, 32'h3c);
    $display("test gating done");

    enter_susp(32'h40);
    toggle(2);
    check("latched no irq", 32'h0, {31'h0, irq});
    rd("latched state", `WK_OFS_STATE, 32'h1a);
    host_wake();
    check("irq after resume", 32'h1, {31'h0, irq});
    check("no resume sent", {24'h0, cnt0}, {24'h0, res_cnt});
    clear_all();
    enter_susp(32'h00);
    toggle(3);
    check("clock on irq", 32'h1, {31'h0, irq});
    host_wake();
    check("no resume sent", {24'h0, cnt0}, {24'h0, res_cnt});
    clear_all();
    $display("test suspend done");

    enter_susp(32'h60);
    toggle(0);
    check("clock woken", 32'h0, {31'h0, clk_stop});
    check("wake irq", 32'h1, {31'h0, irq});
    wr(`WK_OFS_STATUS, 32'h04);
    cw(2);
    check("resume on clear", {24'h0, cnt0 + 8'h01}, {24'h0, res_cnt});
    host_wake();
    wr(`WK_OFS_WAKEUP, 32'h1f);
    enter_susp(32'h60);
    toggle(4);
    cw(WAIT_CYC - 2);
    check("resume not early", {24'h0, cnt0}, {24'h0, res_cnt});
    cw(1);
    check("resume on timeout", {24'h0, cnt0 + 8'h01}, {24'h0, res_cnt});
    host_wake();
    clear_all();
    enter_susp(32'h20);
    toggle(1);
    check("awake irq", 32'h1, {31'h0, irq});
    rd("wait state", `WK_OFS_STATE, 32'h0c);
    host_wake();
    check("host resume no req", {24'h0, cnt0}, {24'h0, res_cnt});
    clear_all();
    wr(`WK_OFS_MASK, 32'h0);
    enter_susp(32'h60);
    toggle(1);
    check("masked stays off", 32'h1, {31'h0, clk_stop});
    host_wake();
    $display("test remote wake done");
    stop_test();
  end
endmodule

// ===== pkg/wk_consts.svh
/*
  Constants of the wake event interrupt block: register offsets, field
  positions, reset values and timing figures.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef WK_CONSTS_SVH
`define WK_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WK_OFS_STATUS   8'h00
`define WK_OFS_MASK     8'h04
`define WK_OFS_CONTROL  8'h08
`define WK_OFS_CONFIG   8'h0c
`define WK_OFS_WAKEUP   8'h10
`define WK_OFS_STATE    8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WK_STA_WAKE_BIT   2
`define WK_STA_SUSP_BIT   4
`define WK_MSK_WAKE_BIT   2
`define WK_CTL_RWE_BIT    5
`define WK_CTL_LPE_BIT    6
`define WK_CFG_P34_BIT    2
`define WK_CFG_P35_BIT    3
`define WK_CFG_CD1_BIT    4
`define WK_CFG_CD2_BIT    5
`define WK_SRC_COUNT      5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WK_RST_BYTE     8'h00
`define WK_RST_SRC      5'h00
`define WK_RST_WORD     32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WK_RESUME_WAIT_MS  10
`define WK_CLK_KHZ         25000
`define WK_PRIME_CYCLES    2'h3

`endif

// ===== pkg/wk_pkg.sv
/*
  Types of the wake event interrupt block.
  Assumes the constants header is on the include path.
*/
package wk_pkg;
  `include "wk_consts.svh"

  // Suspend and resume states
  typedef enum logic [1:0] {
    WK_RUN,
    WK_SUSP_CLK_ON,
    WK_SUSP_CLK_OFF,
    WK_RESUME_WAIT
  } wk_state_e;

  typedef logic [`WK_SRC_COUNT-1:0] wk_src_t;
endpackage

// ===== rtl/wk_wake_irq.sv
/*
  Wake event interrupt controller with remote wakeup, reached over APB.
  Assumes pin inputs are asynchronous; suspend detection and host resume
  strobes come from logic on CLK.
*/
`timescale 1ns/10ps
`include "wk_consts.svh"

// Contract
// - Per-source one-cycle pulses ORed into flag set
// - Interrupt needs flag clear, clock running, mask
// - No retrigger while wake flag stays set
// - Clearing wake flag keeps per-source bits
// - Writing one clears that source bit
// - Suspend wake restarts clock, interrupts, resumes
// - Resume on flag clear or 10 ms
// - Bus-power detection always enabled
// - Clock running in suspend: normal interrupts
// - Clock stopped, no remote wake: latch event, no interrupt
// - Latched event interrupts once clock returns
// - Low-power enable decides clock stop
// - Mask gates interrupt and clock wake
// - Remote wake enable gates resume, clock wake
// - Config bits 2-5 enable four pins
// - Clearing suspend request enters suspend
module wk_wake_irq
  import wk_pkg::*;
#(
  parameter int unsigned RESUME_WAIT_CYCLES = `WK_RESUME_WAIT_MS * `WK_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Wake sources
  input  wire logic        BUS_POWER,
  input  wire logic        PORT3_PIN2,
  input  wire logic        PORT3_PIN3,
  input  wire logic        PORT3_PIN4,
  input  wire logic        PORT3_PIN5,
  // Suspend control
  input  wire logic        SUSPEND_DET,
  input  wire logic        HOST_RESUME,
  output logic             CORE_CLK_STOP,
  output logic             RESUME_REQ,
  output logic             WAKE_IRQ
);

  localparam int unsigned CNT_W = $clog2(RESUME_WAIT_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wk_state_e   state_reg;
  wk_state_e   state_next;
  logic [7:0]  usb_status_reg;
  logic [7:0]  usb_irq_mask_reg;
  logic [7:0]  usb_control_reg;
  logic [7:0]  cpu_config_reg;
  wk_src_t     wakeup_event_reg;
  wk_src_t     pin_raw;
  wk_src_t     sync1_reg;
  wk_src_t     sync2_reg;
  wk_src_t     prev_reg;
  wk_src_t     detect_en;
  wk_src_t     det_pulse;
  logic [1:0]  prime_reg;
  logic        pending_reg;
  logic        resume_reg;
  logic [CNT_W-1:0] wait_cnt_reg;
  logic [31:0] prdata_reg;
  logic        any_event;
  logic        wr_access;
  logic        mask_on;
  logic        rwe_on;
  logic        lpe_on;
  logic        clock_running;
  logic        wake_now;
  logic        wake_clear_wr;
  logic        susp_clear_wr;
  logic        src_clear_wr;
  logic        set_flag;
  logic        wait_done;
  logic        resume_go;
  logic        bus_power_change_pulse;
  logic        pin_three_four_detect_en;
  logic        pin_three_five_detect_en;
  logic        card_one_detect_en;
  logic        card_two_detect_en;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr[31:8] == 24'h00_0000) &&
              (addr[7:0] == `WK_OFS_STATUS  || addr[7:0] == `WK_OFS_MASK   ||
               addr[7:0] == `WK_OFS_CONTROL || addr[7:0] == `WK_OFS_CONFIG ||
               addr[7:0] == `WK_OFS_WAKEUP  || addr[7:0] == `WK_OFS_STATE);
  endfunction

  function automatic logic wr_at(input logic [31:0] addr, input logic [7:0] ofs);
    wr_at = (addr[31:8] == 24'h00_0000) && (addr[7:0] == ofs);
  endfunction

  assign PREADY        = 1'b1;
  assign PSLVERR       = PSEL && PENABLE && !reg_hit(PADDR);
  assign wr_access     = PSEL && PENABLE && PWRITE;
  assign PRDATA        = prdata_reg;

  assign mask_on       = usb_irq_mask_reg[`WK_MSK_WAKE_BIT];
  assign rwe_on        = usb_control_reg[`WK_CTL_RWE_BIT];
  assign lpe_on        = usb_control_reg[`WK_CTL_LPE_BIT];
  assign wake_clear_wr = wr_access && wr_at(PADDR, `WK_OFS_STATUS) && PWDATA[`WK_STA_WAKE_BIT];
  assign susp_clear_wr = wr_access && wr_at(PADDR, `WK_OFS_STATUS) && PWDATA[`WK_STA_SUSP_BIT];
  assign src_clear_wr  = wr_access && wr_at(PADDR, `WK_OFS_WAKEUP);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  assign pin_raw = {PORT3_PIN5, PORT3_PIN4, PORT3_PIN3, PORT3_PIN2, BUS_POWER};

  assign pin_three_four_detect_en = cpu_config_reg[`WK_CFG_P34_BIT];
  assign pin_three_five_detect_en = cpu_config_reg[`WK_CFG_P35_BIT];
  assign card_one_detect_en       = cpu_config_reg[`WK_CFG_CD1_BIT];
  assign card_two_detect_en       = cpu_config_reg[`WK_CFG_CD2_BIT];
  // Bus power has no enable bit
  assign detect_en = {pin_three_five_detect_en, pin_three_four_detect_en,
                      card_two_detect_en, card_one_detect_en, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < `WK_SRC_COUNT; gi++) begin : g_src
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
      // One-cycle pulse per status change
      assign det_pulse[gi] = (prime_reg == `WK_PRIME_CYCLES) && detect_en[gi] &&
                             (sync2_reg[gi] ^ prev_reg[gi]);
    end
  endgenerate

  // Suppress false edges while the synchronisers fill after reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prime_reg <= 2'h0;
    end else if (prime_reg != `WK_PRIME_CYCLES) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  assign bus_power_change_pulse = det_pulse[0];
  assign any_event = bus_power_change_pulse || (|det_pulse[`WK_SRC_COUNT-1:1]);

  // ----------------------------------------------------------------------
  // Suspend state machine
  // ----------------------------------------------------------------------
  // Remote wake needs both mask and enable
  assign wake_now      = any_event && mask_on && rwe_on &&
                         (state_reg == WK_SUSP_CLK_ON || state_reg == WK_SUSP_CLK_OFF);
  assign clock_running = (state_reg != WK_SUSP_CLK_OFF) || wake_now;
  assign wait_done     = (wait_cnt_reg == CNT_W'(RESUME_WAIT_CYCLES - 1));
  assign resume_go     = (state_reg == WK_RESUME_WAIT) && (wake_clear_wr || wait_done);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WK_RUN: begin
        // Clock stops only with low power enabled
        if (susp_clear_wr && usb_status_reg[`WK_STA_SUSP_BIT]) begin
          state_next = lpe_on ? WK_SUSP_CLK_OFF : WK_SUSP_CLK_ON;
        end
      end
      WK_SUSP_CLK_ON, WK_SUSP_CLK_OFF: begin
        if (HOST_RESUME) begin
          state_next = WK_RUN;
        end else if (wake_now) begin
          state_next = WK_RESUME_WAIT;
        end
      end
      WK_RESUME_WAIT: begin
        if (resume_go || HOST_RESUME) begin
          state_next = WK_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= WK_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign CORE_CLK_STOP = (state_reg == WK_SUSP_CLK_OFF);

  // ----------------------------------------------------------------------
  // Resume timer and request
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_cnt_reg <= '0;
    end else if (state_reg != WK_RESUME_WAIT || resume_go) begin
      wait_cnt_reg <= '0;
    end else begin
      wait_cnt_reg <= wait_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      resume_reg <= 1'b0;
    end else begin
      resume_reg <= resume_go && !HOST_RESUME;
    end
  end

  assign RESUME_REQ = resume_reg;

  // ----------------------------------------------------------------------
  // Wake event flag and latched event
  // ----------------------------------------------------------------------
  // Set only when clear, clock running and masked
  assign set_flag = !usb_status_reg[`WK_STA_WAKE_BIT] && mask_on && clock_running &&
                    (any_event || pending_reg);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pending_reg <= 1'b0;
    end else if (any_event && !clock_running) begin
      pending_reg <= 1'b1;
    end else if (clock_running && mask_on) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      usb_status_reg <= `WK_RST_BYTE;
    end else begin
      // Set wins over a same-cycle clear
      if (set_flag) begin
        usb_status_reg[`WK_STA_WAKE_BIT] <= 1'b1;
      end else if (wake_clear_wr) begin
        usb_status_reg[`WK_STA_WAKE_BIT] <= 1'b0;
      end
      if (SUSPEND_DET) begin
        usb_status_reg[`WK_STA_SUSP_BIT] <= 1'b1;
      end else if (susp_clear_wr) begin
        usb_status_reg[`WK_STA_SUSP_BIT] <= 1'b0;
      end
    end
  end

  assign WAKE_IRQ = usb_status_reg[`WK_STA_WAKE_BIT];

  // Per-source record, write one to clear, set wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wakeup_event_reg <= `WK_RST_SRC;
    end else begin
      wakeup_event_reg <= det_pulse |
                          (wakeup_event_reg & ~(src_clear_wr ? PWDATA[`WK_SRC_COUNT-1:0] : `WK_RST_SRC));
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      usb_irq_mask_reg <= `WK_RST_BYTE;
      usb_control_reg  <= `WK_RST_BYTE;
      cpu_config_reg   <= `WK_RST_BYTE;
    end else if (wr_access) begin
      if (wr_at(PADDR, `WK_OFS_MASK)) begin
        usb_irq_mask_reg <= PWDATA[7:0];
      end
      if (wr_at(PADDR, `WK_OFS_CONTROL)) begin
        usb_control_reg <= PWDATA[7:0];
      end
      if (wr_at(PADDR, `WK_OFS_CONFIG)) begin
        cpu_config_reg <= PWDATA[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_reg <= `WK_RST_WORD;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR[7:0])
        `WK_OFS_STATUS:  prdata_reg <= {24'h00_0000, usb_status_reg};
        `WK_OFS_MASK:    prdata_reg <= {24'h00_0000, usb_irq_mask_reg};
        `WK_OFS_CONTROL: prdata_reg <= {24'h00_0000, usb_control_reg};
        `WK_OFS_CONFIG:  prdata_reg <= {24'h00_0000, cpu_config_reg};
        `WK_OFS_WAKEUP:  prdata_reg <= {27'h000_0000, wakeup_event_reg};
        `WK_OFS_STATE:   prdata_reg <= {27'h000_0000, pending_reg, state_reg, CORE_CLK_STOP, resume_reg};
        default:         prdata_reg <= `WK_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_wake_in_suspend;
    state_reg == WK_SUSP_CLK_OFF && any_event && mask_on && rwe_on && !HOST_RESUME;
  endsequence
  sequence s_clock_back;
    !CORE_CLK_STOP && state_reg == WK_RESUME_WAIT;
  endsequence

  chk_flag_cause: assert property ($rose(WAKE_IRQ) |-> $past(any_event || pending_reg))
    else $error("wake flag rose with no event");
  chk_irq_gate: assert property (any_event && !WAKE_IRQ && mask_on && clock_running |=> WAKE_IRQ)
    else $error("enabled event did not raise wake flag");
  chk_no_retrigger: assert property (WAKE_IRQ && !wake_clear_wr |=> WAKE_IRQ)
    else $error("wake flag dropped without clear");
  chk_clear_keeps_src: assert property (wake_clear_wr && !src_clear_wr |=>
                                        ((wakeup_event_reg & $past(wakeup_event_reg)) == $past(wakeup_event_reg)))
    else $error("clearing wake flag lost source bits");
  chk_src_clear: assert property (src_clear_wr && PWDATA[0] && !det_pulse[0] |=> !wakeup_event_reg[0])
    else $error("bus power source bit not cleared");
  chk_wake_clock: assert property (s_wake_in_suspend |=> s_clock_back ##0 WAKE_IRQ)
    else $error("suspend wake did not restart clock");
  chk_resume_bound: assert property (wait_cnt_reg < CNT_W'(RESUME_WAIT_CYCLES))
    else $error("resume wait overran");
  chk_resume_on_clear: assert property (state_reg == WK_RESUME_WAIT && wake_clear_wr && !HOST_RESUME
                                        |=> RESUME_REQ ##1 !RESUME_REQ)
    else $error("resume not sent on flag clear");
  chk_latch_quiet: assert property (CORE_CLK_STOP && any_event && !rwe_on |=> pending_reg && !$rose(WAKE_IRQ))
    else $error("stopped clock event not latched quietly");
  chk_latched_fires: assert property (pending_reg && !CORE_CLK_STOP && mask_on && !WAKE_IRQ |=> WAKE_IRQ)
    else $error("latched event not raised");
  chk_lp_entry: assert property (state_reg == WK_RUN && susp_clear_wr && usb_status_reg[`WK_STA_SUSP_BIT]
                                 |=> CORE_CLK_STOP == $past(lpe_on))
    else $error("suspend entry ignored low power enable");

endmodule
